//--- hw/pwm_timebase_pkg.sv
// package for the switch-mode pwm event/time-base core
// assumes a 32-bit classic wishbone slave with byte-wide registers
package pwm_timebase_pkg;

  // ----------------------------------------------------------------
  // register byte addresses, one aligned word each
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_PRESCALE  = 8'h04;
  localparam logic [7:0] ADDR_PER_SRC   = 8'h08;
  localparam logic [7:0] ADDR_RISE_SRC  = 8'h0c;
  localparam logic [7:0] ADDR_FALL_SRC  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CTRL  = 8'h14;
  localparam logic [7:0] ADDR_TMR_LOW   = 8'h18;
  localparam logic [7:0] ADDR_TMR_HIGH  = 8'h1c;
  localparam logic [7:0] ADDR_PER_LOW   = 8'h20;
  localparam logic [7:0] ADDR_PER_HIGH  = 8'h24;
  localparam logic [7:0] ADDR_PH_LOW    = 8'h28;
  localparam logic [7:0] ADDR_PH_HIGH   = 8'h2c;
  localparam logic [7:0] ADDR_DUTY_LOW  = 8'h30;
  localparam logic [7:0] ADDR_DUTY_HIGH = 8'h34;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT   = 7;  // module enable
  localparam int CTRL_LD_BIT   = 6;  // load request
  // irq control: flags in low nibble, enables in high nibble
  localparam int FLAG_OVF_BIT  = 0;
  localparam int FLAG_PER_BIT  = 1;
  localparam int FLAG_PH_BIT   = 2;
  localparam int FLAG_DUTY_BIT = 3;
  localparam int NUM_FLAGS     = 4;
  // source select: bit0 timer match, bit1 pin, bits2..4 comparators
  localparam int NUM_SRC       = 5;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [15:0] PER_RESET = 16'hffff;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [2:0]  PRE_ONE   = 3'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] period;
    logic [15:0] phase;
    logic [15:0] duty;
  } compare_set_t;

  typedef struct packed {
    logic cmpThree;
    logic cmpTwo;
    logic cmpOne;
    logic pin;
  } async_in_t;

endpackage

//--- hw/switch_mode_pwm_event_timebase.sv
// event sequencing and 16-bit time base of a switch-mode pwm controller
// assumes wishbone classic master on clk_sys; async inputs from pins
//
// Functional notes
// - period event is any selected mix of period match, pin, comparators.
// - period event clears counter next tick; counting resumes tick after.
// - only first rising and first falling event per period take effect.
// - rising event after a falling event in same period is suppressed.
// - rising event from selected mix of phase match, pin, comparators.
// - falling event from selected mix of duty match, pin, comparators.
// - accepted edges drive outputs directly with no extra alignment.
// - accepted rising event strobes falling blanking and dead-band start.
// - accepted falling event strobes rising blanking and dead-band start.
// - compare writes held until load request, applied at period reset.
// - counter starts at zero, increments each tick up to all ones.
// - wrap from all ones to zero without period event sets overflow flag.
// - counter readable as separate low and high byte registers.
// - clearing enable returns counter to reset value.
// - counter equal to active period makes period event, sets flag.
// - counter equal to active phase makes rising event, sets flag.
// - counter equal to active duty makes falling event, sets flag.
// - period held in byte pair plus shadow copy loaded at period reset.
// - phase byte pair is double buffered like the period.
// - duty byte pair is double buffered, shadow updated at period reset.
// - synchronous period lasts period value plus one ticks.
// - flags set on their event regardless of enable bits.
// - clearing enable clears all local time-base flags.
// - tick is clock divided by prescale of 1, 2, 4 or 8.
// - asynchronous inputs trigger on rising transition only.
module switch_mode_pwm_event_timebase (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        eventInputPin,
  input  wire logic        cmpOneSyncOut,
  input  wire logic        cmpTwoSyncOut,
  input  wire logic        cmpThreeSyncOut,
  output logic             riseStrobe,
  output logic             fallStrobe,
  output logic             pulseActive,
  output logic             periodStrobe
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  pwm_timebase_pkg::async_in_t asyncRaw, syncA_r, syncB_r, syncC_r;
  assign asyncRaw = '{cmpThree: cmpThreeSyncOut, cmpTwo: cmpTwoSyncOut,
                      cmpOne: cmpOneSyncOut, pin: eventInputPin};

  // two stages, then a third for edge detect; only syncB reads syncA
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      syncA_r <= '0;
      syncB_r <= '0;
      syncC_r <= '0;
    end else begin
      syncA_r <= asyncRaw;
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
    end
  end

  // rising transitions only, never levels
  logic [3:0] asyncRise;
  assign asyncRise = syncB_r & ~syncC_r;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic                  enable_r, loadReq_r;
  logic [2:0]            preSel_r;
  logic [pwm_timebase_pkg::NUM_SRC-1:0] perSrc_r, riseSrc_r, fallSrc_r;
  logic [pwm_timebase_pkg::NUM_FLAGS-1:0] flags_r, flagEn_r, flagSet;
  logic [pwm_timebase_pkg::NUM_FLAGS-1:0] flags_nxt;
  pwm_timebase_pkg::compare_set_t userVal_r, activeVal_r;
  logic [15:0]           count_r, count_nxt;

  wire wbReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wbWr    = wbReq & wb_we_i & wb_sel_i[0];
  wire [7:0] wrByte = wb_dat_i[7:0];
  wire wrCtrl  = wbWr && wb_adr_i == pwm_timebase_pkg::ADDR_CTRL;
  wire wrIrq   = wbWr && wb_adr_i == pwm_timebase_pkg::ADDR_IRQ_CTRL;

  // ----------------------------------------------------------------
  // prescaler: one-cycle tick enable
  // ----------------------------------------------------------------
  logic [2:0] preCnt_r;
  logic       tick;
  // prescale code 0..3 selects divide by 1,2,4,8
  wire [2:0] preMask = 3'((4'h1 << preSel_r[1:0]) - 4'h1);
  assign tick = enable_r && ((preCnt_r & preMask) == preMask);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) preCnt_r <= pwm_timebase_pkg::PRE_ONE;
    else if (!enable_r) preCnt_r <= pwm_timebase_pkg::PRE_ONE;
    else preCnt_r <= 3'(preCnt_r + 3'h1);
  end

  // ----------------------------------------------------------------
  // event formation
  // ----------------------------------------------------------------
  wire perMatch  = enable_r && count_r == activeVal_r.period;
  wire phMatch   = enable_r && count_r == activeVal_r.phase;
  wire dutyMatch = enable_r && count_r == activeVal_r.duty;
  // synchronous matches counted once per tick
  wire [4:0] perIn  = {asyncRise, perMatch & tick};
  wire [4:0] riseIn = {asyncRise, phMatch & tick};
  wire [4:0] fallIn = {asyncRise, dutyMatch & tick};
  wire perEvent  = enable_r && |(perIn & perSrc_r);
  wire riseEvent = enable_r && |(riseIn & riseSrc_r);
  wire fallEvent = enable_r && |(fallIn & fallSrc_r);

  // per-period bookkeeping; reset pending until next tick
  logic riseDone_r, fallDone_r, resetPend_r;
  wire riseAccept = riseEvent & ~riseDone_r & ~fallDone_r;
  wire fallAccept = fallEvent & ~fallDone_r;
  assign riseStrobe   = riseAccept;
  assign fallStrobe   = fallAccept;
  assign periodStrobe = perEvent;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      riseDone_r <= 1'b0;
      fallDone_r <= 1'b0;
    end else if (!enable_r || perEvent) begin
      riseDone_r <= 1'b0;
      fallDone_r <= 1'b0;
    end else begin
      riseDone_r <= riseDone_r | riseAccept;
      fallDone_r <= fallDone_r | fallAccept;
    end
  end

  // active pulse follows accepted edges in the same cycle
  logic pulse_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) pulse_r <= 1'b0;
    else if (!enable_r || fallAccept) pulse_r <= 1'b0;
    else if (riseAccept) pulse_r <= 1'b1;
  end
  // combinational so the edge needs no further clock alignment
  assign pulseActive = (pulse_r | riseAccept) & ~fallAccept;

  // ----------------------------------------------------------------
  // time base counter
  // ----------------------------------------------------------------
  // any period event on a tick clears at once, else it waits for one
  wire periodReset = tick & (resetPend_r | perEvent);
  always_comb begin
    count_nxt = count_r;
    if (!enable_r) count_nxt = pwm_timebase_pkg::CNT_RESET;
    else if (periodReset) count_nxt = pwm_timebase_pkg::CNT_RESET;
    else if (tick) count_nxt = 16'(count_r + 16'h0001);
  end

  // async period event between ticks waits for the next tick
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_r     <= pwm_timebase_pkg::CNT_RESET;
      resetPend_r <= 1'b0;
    end else begin
      count_r     <= count_nxt;
      resetPend_r <= enable_r & ~tick & (resetPend_r | perEvent);
    end
  end

  // wrap without period event
  wire overflow = tick && !periodReset && count_r == pwm_timebase_pkg::CNT_MAX;

  // ----------------------------------------------------------------
  // double buffered compare values
  // ----------------------------------------------------------------
  // shadow copies take the user bytes only on a period reset after load
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      activeVal_r <= '{period: pwm_timebase_pkg::PER_RESET,
                       phase: pwm_timebase_pkg::CNT_RESET,
                       duty: pwm_timebase_pkg::CNT_RESET};
    end else if (periodReset && loadReq_r) begin
      activeVal_r <= userVal_r;
    end
  end

  // ----------------------------------------------------------------
  // flags: hardware set beats software clear
  // ----------------------------------------------------------------
  assign flagSet[pwm_timebase_pkg::FLAG_OVF_BIT]  = overflow;
  assign flagSet[pwm_timebase_pkg::FLAG_PER_BIT]  = perMatch & tick;
  assign flagSet[pwm_timebase_pkg::FLAG_PH_BIT]   = phMatch & tick;
  assign flagSet[pwm_timebase_pkg::FLAG_DUTY_BIT] = dutyMatch & tick;

  genvar gi;
  generate
    for (gi = 0; gi < pwm_timebase_pkg::NUM_FLAGS; gi++) begin : g_flag
      always_comb begin
        flags_nxt[gi] = flags_r[gi];
        if (wrIrq) flags_nxt[gi] = wrByte[gi];
        if (flagSet[gi]) flags_nxt[gi] = 1'b1;
        if (!enable_r) flags_nxt[gi] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      enable_r  <= 1'b0;
      loadReq_r <= 1'b0;
      preSel_r  <= pwm_timebase_pkg::PRE_ONE;
      perSrc_r  <= '0;
      riseSrc_r <= '0;
      fallSrc_r <= '0;
      flags_r   <= '0;
      flagEn_r  <= '0;
      userVal_r <= '{period: pwm_timebase_pkg::PER_RESET,
                     phase: pwm_timebase_pkg::CNT_RESET,
                     duty: pwm_timebase_pkg::CNT_RESET};
    end else begin
      flags_r <= flags_nxt;
      // load request self clears once applied; a new request wins
      if (wrCtrl) begin
        enable_r  <= wrByte[pwm_timebase_pkg::CTRL_EN_BIT];
        loadReq_r <= wrByte[pwm_timebase_pkg::CTRL_LD_BIT];
      end else if (periodReset) begin
        loadReq_r <= 1'b0;
      end
      if (wrIrq) flagEn_r <= wrByte[7:4];
      if (wbWr) begin
        unique case (wb_adr_i)
          pwm_timebase_pkg::ADDR_PRESCALE: preSel_r <= {1'b0, wrByte[1:0]};
          pwm_timebase_pkg::ADDR_PER_SRC:  perSrc_r  <= wrByte[4:0];
          pwm_timebase_pkg::ADDR_RISE_SRC: riseSrc_r <= wrByte[4:0];
          pwm_timebase_pkg::ADDR_FALL_SRC: fallSrc_r <= wrByte[4:0];
          pwm_timebase_pkg::ADDR_PER_LOW:  userVal_r.period[7:0]  <= wrByte;
          pwm_timebase_pkg::ADDR_PER_HIGH: userVal_r.period[15:8] <= wrByte;
          pwm_timebase_pkg::ADDR_PH_LOW:   userVal_r.phase[7:0]   <= wrByte;
          pwm_timebase_pkg::ADDR_PH_HIGH:  userVal_r.phase[15:8]  <= wrByte;
          pwm_timebase_pkg::ADDR_DUTY_LOW: userVal_r.duty[7:0]    <= wrByte;
          pwm_timebase_pkg::ADDR_DUTY_HIGH: userVal_r.duty[15:8]  <= wrByte;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux and ack
  // ----------------------------------------------------------------
  logic [7:0] rdByte;
  always_comb begin
    rdByte = pwm_timebase_pkg::BYTE_ZERO;
    unique case (wb_adr_i)
      pwm_timebase_pkg::ADDR_CTRL:
        rdByte = {enable_r, loadReq_r, 6'h00};
      pwm_timebase_pkg::ADDR_PRESCALE: rdByte = {6'h00, preSel_r[1:0]};
      pwm_timebase_pkg::ADDR_PER_SRC:  rdByte = {3'h0, perSrc_r};
      pwm_timebase_pkg::ADDR_RISE_SRC: rdByte = {3'h0, riseSrc_r};
      pwm_timebase_pkg::ADDR_FALL_SRC: rdByte = {3'h0, fallSrc_r};
      pwm_timebase_pkg::ADDR_IRQ_CTRL: rdByte = {flagEn_r, flags_r};
      pwm_timebase_pkg::ADDR_TMR_LOW:  rdByte = count_r[7:0];
      pwm_timebase_pkg::ADDR_TMR_HIGH: rdByte = count_r[15:8];
      pwm_timebase_pkg::ADDR_PER_LOW:  rdByte = userVal_r.period[7:0];
      pwm_timebase_pkg::ADDR_PER_HIGH: rdByte = userVal_r.period[15:8];
      pwm_timebase_pkg::ADDR_PH_LOW:   rdByte = userVal_r.phase[7:0];
      pwm_timebase_pkg::ADDR_PH_HIGH:  rdByte = userVal_r.phase[15:8];
      pwm_timebase_pkg::ADDR_DUTY_LOW: rdByte = userVal_r.duty[7:0];
      pwm_timebase_pkg::ADDR_DUTY_HIGH: rdByte = userVal_r.duty[15:8];
      default: rdByte = pwm_timebase_pkg::BYTE_ZERO;
    endcase
  end

  // one wait state; unmapped reads give zero and still ack
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= wbReq ? {24'h000000, rdByte} : '0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  rise_once_a: assert property (
    riseStrobe |=> !riseStrobe until perEvent)
    else $error("second rising event in one period");
  rise_after_fall_a: assert property (
    fallDone_r && !perEvent |-> !riseStrobe)
    else $error("rising event after falling accepted");
  counter_clear_a: assert property (periodReset |=> count_r == 16'h0000)
    else $error("counter not cleared on period reset");
  count_step_a: assert property (tick && !periodReset && enable_r
                  |=> count_r == 16'($past(count_r) + 16'h0001))
    else $error("counter did not step on tick");
  // strobes checked in the disabled cycle itself: the next one may be enabled
  disabled_zero_a: assert property (
    !enable_r |-> (!riseStrobe && !fallStrobe && !periodStrobe)
    ##1 (count_r == pwm_timebase_pkg::CNT_RESET))
    else $error("counter or strobes moved while disabled");
  flags_clear_a: assert property (!enable_r |=> flags_r == 4'h0)
    else $error("flags survived disable");
  shadow_hold_a: assert property (!(periodReset && loadReq_r)
                  |=> activeVal_r == $past(activeVal_r))
    else $error("shadow changed without load");
  overflow_flag_a: assert property (overflow && enable_r |=> flags_r[0])
    else $error("overflow flag not set");
  async_edge_a: assert property (syncB_r[0] && syncC_r[0] |-> !asyncRise[0])
    else $error("level acted as event");
  ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  load_cover_c:  cover property (periodReset && loadReq_r);
  skip_cover_c:  cover property (fallDone_r && riseEvent && !perEvent);
  ovf_cover_c:   cover property (overflow);
  pulse_cover_c: cover property (riseStrobe ##[1:50] fallStrobe);

endmodule

//--- testbench/event_source_model.sv
// partner model: event input pin and three synced comparator outputs
// assumes fire requests come as one-cycle pulses timed to clk_sys
module event_source_model (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic [3:0]             fireMask,
  output pwm_timebase_pkg::async_in_t lines
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] lineVec_r;
  logic [2:0] hold_r [4];

  // --------------------------------------------------------------
  // pulse shaping
  // --------------------------------------------------------------
  // each fire gives one short high pulse, then idle low, so the
  // block sees a single rising edge and never a standing level
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lineVec_r <= 4'h0;
      for (int i = 0; i < 4; i++) hold_r[i] <= 3'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (fireMask[i]) begin
          lineVec_r[i] <= 1'b1;
          hold_r[i]    <= 3'h4;
        end else if (hold_r[i] != 3'h0) begin
          hold_r[i]    <= hold_r[i] - 3'h1;
          lineVec_r[i] <= (hold_r[i] != 3'h1);
        end
      end
    end
  end

  assign lines = pwm_timebase_pkg::async_in_t'(lineVec_r);
endmodule

//--- testbench/switch_mode_pwm_event_timebase_tb.sv
// testbench: registers, time base, event sequencing of the pwm core
// assumes event_source_model drives the pin and comparator inputs
module switch_mode_pwm_event_timebase_tb;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [7:0] a;
    logic [3:0] s;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;

  localparam int LIMIT = 90000;  // the wrap test alone needs ~66k
  logic                        clk_sys, rstn, cyc, stb, we, ack;
  logic                        riseStrobe, fallStrobe;
  logic                        pulseActive, periodStrobe;
  logic [7:0]                  adr;
  logic [3:0]                  sel, fireMask;
  logic [31:0]                 datW, datR, q;
  pwm_timebase_pkg::async_in_t lines;
  int                          miscompares = 0, n_tests = 0, cycles = 0;
  int                          riseCnt = 0, fallCnt = 0, perCnt = 0;
  int                          lastRise, lastFall, lastPer, p1, r0, f0, n;

  // write with sel, then read back; sel 0 writes must be ignored
  row_t rows [17] = '{
    '{pwm_timebase_pkg::ADDR_PER_LOW,   4'h0, 8'h12, 8'hff},
    '{pwm_timebase_pkg::ADDR_PER_HIGH,  4'h0, 8'h12, 8'hff},
    '{pwm_timebase_pkg::ADDR_PER_HIGH,  4'hf, 8'h00, 8'h00},
    '{pwm_timebase_pkg::ADDR_PER_LOW,   4'hf, 8'h09, 8'h09},
    '{pwm_timebase_pkg::ADDR_PH_LOW,    4'h0, 8'hff, 8'h00},
    '{pwm_timebase_pkg::ADDR_PH_LOW,    4'hf, 8'h02, 8'h02},
    '{pwm_timebase_pkg::ADDR_DUTY_HIGH, 4'h0, 8'hff, 8'h00},
    '{pwm_timebase_pkg::ADDR_DUTY_LOW,  4'hf, 8'h05, 8'h05},
    '{pwm_timebase_pkg::ADDR_PRESCALE,  4'hf, 8'h03, 8'h03},
    '{pwm_timebase_pkg::ADDR_PRESCALE,  4'hf, 8'h00, 8'h00},
    '{pwm_timebase_pkg::ADDR_PER_SRC,   4'hf, 8'h03, 8'h03},
    '{pwm_timebase_pkg::ADDR_RISE_SRC,  4'hf, 8'h01, 8'h01},
    '{pwm_timebase_pkg::ADDR_FALL_SRC,  4'hf, 8'h01, 8'h01},
    '{pwm_timebase_pkg::ADDR_IRQ_CTRL,  4'hf, 8'h5f, 8'h50},
    '{pwm_timebase_pkg::ADDR_TMR_HIGH,  4'hf, 8'hff, 8'h00},
    '{pwm_timebase_pkg::ADDR_CTRL,      4'hf, 8'h00, 8'h00},
    '{8'h3c,                            4'hf, 8'h55, 8'h00}
  };

  switch_mode_pwm_event_timebase uut (
    .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
    .wb_dat_o(datR), .wb_ack_o(ack), .eventInputPin(lines.pin),
    .cmpOneSyncOut(lines.cmpOne), .cmpTwoSyncOut(lines.cmpTwo),
    .cmpThreeSyncOut(lines.cmpThree), .riseStrobe(riseStrobe),
    .fallStrobe(fallStrobe), .pulseActive(pulseActive),
    .periodStrobe(periodStrobe));

  event_source_model model (.clk_sys(clk_sys), .rstn(rstn),
    .fireMask(fireMask), .lines(lines));

  // --------------------------------------------------------------
  // clock, strobe monitor, watchdog
  // --------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // strobes are single-cycle, so stamp them at every edge
  always @(posedge clk_sys) begin
    cycles++;
    if (riseStrobe === 1'b1) begin
      riseCnt++;
      lastRise = cycles;
    end
    if (fallStrobe === 1'b1) begin
      fallCnt++;
      lastFall = cycles;
    end
    if (periodStrobe === 1'b1) begin
      perCnt++;
      lastPer = cycles;
    end
    if (cycles == LIMIT) begin
      miscompares++;
      results();
    end
  end

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  // classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [3:0] s, input logic [7:0] d);
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    datW <= {24'h0, d};
    // only the watchdog ends a wait that never sees ack
    do @(posedge clk_sys);
    while (ack !== 1'b1);
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(a, 1'b1, 4'hf, d);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(a, 1'b0, 4'hf, 8'h00);
  endtask

  // 0 period, 1 rise, 2 fall; the delay lets the monitor stamp first
  task automatic waitHi(input int w);
    do @(posedge clk_sys);
    while ((w == 0 ? periodStrobe : w == 1 ? riseStrobe : fallStrobe)
           !== 1'b1);
    #1;
  endtask

  task automatic fire(input logic [3:0] m);
    @(posedge clk_sys);
    fireMask <= m;
    @(posedge clk_sys);
    fireMask <= 4'h0;
  endtask

  task automatic results;
    $display("miscompares %0d, n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {cyc, stb, we, adr, sel, datW, fireMask} = '0;
    rstn = 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      wb(rows[i].a, 1'b1, rows[i].s, rows[i].d);
      rd(rows[i].a);
      chk("register", {24'h0, rows[i].e}, q);
    end
    // enable with load pending; old period shadow must still rule
    wr(pwm_timebase_pkg::ADDR_CTRL, 8'hc0);
    r0 = perCnt;
    repeat (30) @(posedge clk_sys);
    chk("held period", 0, perCnt - r0);
    fire(4'h1);
    waitHi(0);
    for (int p = 0; p < 4; p++) begin
      wr(pwm_timebase_pkg::ADDR_PRESCALE, 8'(p));
      waitHi(0);
      p1 = lastPer;
      waitHi(0);
      chk("period length", 10 << p, lastPer - p1);
      if (p == 0) begin
        chk("rise offset", 3, lastRise - p1);
        chk("pulse width", 3, lastFall - lastRise);
      end
    end
    wr(pwm_timebase_pkg::ADDR_PRESCALE, 8'h00);
    rd(pwm_timebase_pkg::ADDR_IRQ_CTRL);
    chk("flags", 8'h5e, q);
    waitHi(1);
    @(posedge clk_sys);
    chk("active after rise", 1, pulseActive);
    waitHi(2);
    @(posedge clk_sys);
    chk("active after fall", 0, pulseActive);
    // long period, pin rises, comparator one ends the pulse early
    wr(pwm_timebase_pkg::ADDR_PER_LOW, 8'hc8);
    wr(pwm_timebase_pkg::ADDR_DUTY_LOW, 8'h64);
    wr(pwm_timebase_pkg::ADDR_RISE_SRC, 8'h02);
    wr(pwm_timebase_pkg::ADDR_FALL_SRC, 8'h05);
    // pin must not also end the period, or the once-rules restart
    wr(pwm_timebase_pkg::ADDR_PER_SRC, 8'h01);
    wr(pwm_timebase_pkg::ADDR_CTRL, 8'hc0);
    waitHi(0);
    waitHi(0);
    p1 = lastPer;
    rd(pwm_timebase_pkg::ADDR_CTRL);
    chk("load bit", 8'h80, q);
    r0 = riseCnt;
    f0 = fallCnt;
    fire(4'h1);
    repeat (10) @(posedge clk_sys);
    fire(4'h3);
    waitHi(0);
    chk("rises", 1, riseCnt - r0);
    chk("falls", 1, fallCnt - f0);
    chk("early fall", 1, (lastFall - p1) < 40);
    r0 = riseCnt;
    fire(4'h2);
    repeat (10) @(posedge clk_sys);
    fire(4'h1);
    waitHi(0);
    chk("rise after fall", 0, riseCnt - r0);
    wr(pwm_timebase_pkg::ADDR_RISE_SRC, 8'h00);
    wr(pwm_timebase_pkg::ADDR_FALL_SRC, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(pwm_timebase_pkg::ADDR_PER_SRC, 8'(2 << i));
      r0 = perCnt;
      fire(4'(1 << i));
      repeat (10) @(posedge clk_sys);
      chk("selected source", 1, perCnt - r0);
      rd(pwm_timebase_pkg::ADDR_TMR_LOW);
      chk("cleared count", 1, q < 32'h10);
      fire(4'(1 << ((i + 1) % 4)));
      repeat (10) @(posedge clk_sys);
      chk("other source", 1, perCnt - r0);
    end
    // disable: counter and flags drop, events stop
    wr(pwm_timebase_pkg::ADDR_CTRL, 8'h00);
    rd(pwm_timebase_pkg::ADDR_TMR_LOW);
    chk("counter off", 0, q);
    rd(pwm_timebase_pkg::ADDR_IRQ_CTRL);
    chk("flags off", 8'h50, q);
    r0 = perCnt + riseCnt + fallCnt;
    fire(4'hf);
    repeat (10) @(posedge clk_sys);
    chk("strobes off", 0, perCnt + riseCnt + fallCnt - r0);
    // free run to the wrap; software flag writes on the way
    wr(pwm_timebase_pkg::ADDR_PER_SRC, 8'h00);
    wr(pwm_timebase_pkg::ADDR_CTRL, 8'h80);
    repeat (120) @(posedge clk_sys);
    wr(pwm_timebase_pkg::ADDR_IRQ_CTRL, 8'h01);
    rd(pwm_timebase_pkg::ADDR_IRQ_CTRL);
    chk("flag write", 8'h01, q);
    wr(pwm_timebase_pkg::ADDR_IRQ_CTRL, 8'h00);
    n = 0;
    do begin
      rd(pwm_timebase_pkg::ADDR_IRQ_CTRL);
      n++;
    end while (q[0] !== 1'b1 && n < 30000);
    chk("wrap time", 1, n > 20000 && n < 30000);
    rd(pwm_timebase_pkg::ADDR_TMR_HIGH);
    chk("after wrap", 0, q);
    // mid-run reset: control and period bytes back to reset values
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(pwm_timebase_pkg::ADDR_CTRL);
    chk("reset ctrl", 0, q);
    rd(pwm_timebase_pkg::ADDR_PER_HIGH);
    chk("reset period", 8'hff, q);
    results();
  end
endmodule
